// ===== pkg/eeprom_cfg.svh
// constants for the serial eeprom link, both ends
`ifndef EEPROM_CFG_SVH
`define EEPROM_CFG_SVH
`define CLK_PERIOD_NS     25
`define ADDR_W            9
`define OPC_TOP           4'h0
`define OPC_SET_LATCH     3'h6
`define OPC_CLEAR_LATCH   3'h4
`define OPC_STATUS_READ   3'h5
`define OPC_STATUS_WRITE  3'h1
`define OPC_READ          3'h3
`define OPC_WRITE         3'h2
`define ST_BUSY           0
`define ST_LATCH          1
`define ST_LEVEL_LO       2
`define ST_LEVEL_HI       3
`define STATUS_BUSY_VAL   8'hFF
`define WRITE_TIME_NS     10000000
`define WRITE_CYCLES      (`WRITE_TIME_NS / `CLK_PERIOD_NS)
`define SCK_HALF_CYCLES   4
`define CS_TIME_NS        250
`define CS_CYCLES         ((`CS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REG_CMD           8'h00
`define REG_ADDR          8'h04
`define REG_WDATA0        8'h08
`define REG_WDATA1        8'h0C
`define REG_RDATA0        8'h10
`define REG_RDATA1        8'h14
`define REG_CTRL          8'h18
`define REG_STATUS        8'h1C
`define CMD_HAS_ADDR      8
`define CTRL_PAUSE        0
`define CTRL_WP_LEVEL     1
`define HST_BUSY          0
`define HST_DONE          1
`define HST_HELD          2
`endif

// ===== pkg/eeprom_pkg.sv
// types shared by both ends of the serial eeprom link
package eeprom_pkg;
    typedef enum logic [2:0] {
        DEV_IDLE   = 3'h0,
        DEV_OPCODE = 3'h1,
        DEV_ADDR   = 3'h3,
        DEV_WDATA  = 3'h2,
        DEV_RDATA  = 3'h6,
        DEV_STATUS = 3'h7,
        DEV_SWRITE = 3'h5,
        DEV_IGNORE = 3'h4
    } dev_state_t;
    typedef enum logic [1:0] {
        HOST_IDLE     = 2'h0,
        HOST_SHIFT    = 2'h1,
        HOST_DESELECT = 2'h3,
        HOST_RECOVER  = 2'h2
    } host_state_t;
    typedef enum logic [1:0] {
        PEND_NONE   = 2'h0,
        PEND_ARRAY  = 2'h1,
        PEND_STATUS = 2'h3
    } pend_t;
endpackage : eeprom_pkg

// ===== pkg/eeprom_if.sv
// serial link between the eeprom and its controller
`timescale 1ns/10ps
interface eeprom_if;
    logic csN;
    logic sck;
    logic si;
    logic holdN;
    logic wpN;
    logic soOut;
    logic soOe;
    logic so;
    // released line is pulled high
    assign so = soOe ? soOut : 1'b1;
    modport dev (input csN, sck, si, holdN, wpN, output soOut, soOe);
    modport host (output csN, sck, si, holdN, wpN, input so);
endinterface : eeprom_if

// ===== hw/spi_eeprom_dev.sv
// serial eeprom device end: command decoder, protection and self-timed write
// Function
// - select falling starts frame; opcode first, msb first
// - decode set latch, clear latch, status read
// - decode status write, read, write; bit3 addresses
// - bad opcode: ignore input, output off
// - deselected: ignore input, output off
// - pause keeps sequence, ignores input, output off
// - write protect low inhibits and aborts writes
// - started write cycle always completes
// - latch clear at reset; master sets it first
// - clear latch works regardless of protect pin
// - status: busy, latch, protect level bits
// - upper bits zero; all ones while busy
// - protect level selects none, quarter, half, all
// - protect level written by timed cycle
// - read takes address then shifts data out
// - read continues with wrapping address increment
// - program only enabled, unprotected, protect pin high
// - while busy only status read accepted
// - programming starts when select rises after byte
// - page write wraps within eight bytes
// - latch cleared when write cycle ends
// - refused write returns to standby on deselect
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "eeprom_cfg.svh"
module spi_eeprom_dev #(
    parameter int WC_CYCLES = `WRITE_CYCLES
) (
    input  logic        clk,
    input  logic        rst_b,
    eeprom_if.dev       link,
    output logic        writeBusy,
    output logic [1:0]  protectLevel
);
    import eeprom_pkg::*;

    localparam int AW    = `ADDR_W;
    localparam int DEPTH = 1 << AW;
    localparam int CW    = $clog2(WC_CYCLES + 1);

    typedef struct packed {
        logic [1:0]              csS;
        logic [1:0]              sckS;
        logic [1:0]              siS;
        logic [1:0]              holdS;
        logic [1:0]              wpS;
        logic                    sckPrev;
        logic                    csPrev;
        dev_state_t              state;
        logic [2:0]              bitCnt;
        logic [7:0]              inShift;
        logic [7:0]              outShift;
        logic                    outEna;
        logic                    fresh;
        logic                    held;
        logic                    wpDrop;
        logic                    isRead;
        logic                    gotByte;
        logic                    latch;
        logic [1:0]              level;
        logic [1:0]              pendLevel;
        logic [AW-1:0]           addr;
        logic [7:0][7:0]         page;
        logic [7:0]              pageMask;
        pend_t                   pend;
        logic [CW-1:0]           busyCnt;
        logic [DEPTH-1:0][7:0]   mem;
    } dev_regs_t;

    dev_regs_t r;
    dev_regs_t n;

    function automatic logic isProtected(input logic [AW-1:0] a, input logic [1:0] lvl);
        case (lvl)
            2'h0:    isProtected = 1'b0;
            2'h1:    isProtected = (a[AW-1:AW-2] == 2'h3);
            2'h2:    isProtected = a[AW-1];
            default: isProtected = 1'b1;
        endcase
    endfunction : isProtected

    logic [7:0] statusByte;
    assign statusByte = (r.pend != PEND_NONE) ? `STATUS_BUSY_VAL
                                              : {4'h0, r.level, r.latch, 1'b0};

    always_comb
    begin
        logic          sel;
        logic          rise;
        logic          fall;
        logic          busy;
        logic          byteDone;
        logic [7:0]    b;
        logic [AW-1:0] nextAddr;
        sel      = 1'b0;
        rise     = 1'b0;
        fall     = 1'b0;
        busy     = 1'b0;
        byteDone = 1'b0;
        b        = 8'h00;
        nextAddr = '0;
        n = r;
        n.csS   = {r.csS[0], link.csN};
        n.sckS  = {r.sckS[0], link.sck};
        n.siS   = {r.siS[0], link.si};
        n.holdS = {r.holdS[0], link.holdN};
        n.wpS   = {r.wpS[0], link.wpN};
        n.sckPrev = r.sckS[1];
        n.csPrev  = r.csS[1];
        sel  = !r.csS[1];
        rise = r.sckS[1] && !r.sckPrev;
        fall = !r.sckS[1] && r.sckPrev;
        busy = (r.pend != PEND_NONE);
        b    = {r.inShift[6:0], r.siS[1]};
        byteDone = (r.bitCnt == 3'h7);
        if (!r.sckS[1])
            n.held = !r.holdS[1];
        if (!r.wpS[1])
            n.wpDrop = 1'b1;
        // self-timed cycle runs on whatever the pins do
        if (busy)
        begin
            if (r.busyCnt == '0)
            begin
                if (r.pend == PEND_ARRAY)
                begin
                    for (int i = 0; i < 8; i++)
                        if (r.pageMask[i])
                            n.mem[{r.addr[AW-1:3], 3'(i)}] = r.page[i];
                end
                else
                    n.level = r.pendLevel;
                n.latch = 1'b0;
                n.pend  = PEND_NONE;
            end
            else
                n.busyCnt = r.busyCnt - CW'(1);
        end
        if (sel && r.csPrev)
        begin
            n.state   = DEV_OPCODE;
            n.bitCnt  = 3'h0;
            n.outEna  = 1'b0;
            n.gotByte = 1'b0;
            n.wpDrop  = !r.wpS[1];
        end
        else if (!sel)
        begin
            if (!r.csPrev && r.bitCnt == 3'h0 && r.gotByte && r.latch && r.wpS[1] && !r.wpDrop)
            begin
                if (r.state == DEV_WDATA && !isProtected(r.addr, r.level))
                begin
                    n.pend    = PEND_ARRAY;
                    n.busyCnt = CW'(WC_CYCLES - 1);
                end
                else if (r.state == DEV_SWRITE)
                begin
                    n.pend    = PEND_STATUS;
                    n.busyCnt = CW'(WC_CYCLES - 1);
                end
            end
            n.state  = DEV_IDLE;
            n.outEna = 1'b0;
        end
        else if (!r.held && rise && r.state != DEV_IGNORE && r.state != DEV_IDLE)
        begin
            n.inShift = b;
            n.bitCnt  = r.bitCnt + 3'h1;
            if (byteDone)
            begin
                case (r.state)
                    DEV_OPCODE:
                    begin
                        n.state = DEV_IGNORE;
                        if (b[7:4] != `OPC_TOP)
                            n.state = DEV_IGNORE;
                        else if (busy && b[2:0] != `OPC_STATUS_READ)
                            n.state = DEV_IGNORE;
                        else
                        begin
                            case (b[2:0])
                                `OPC_SET_LATCH:
                                    n.latch = r.wpS[1] ? 1'b1 : r.latch;
                                `OPC_CLEAR_LATCH:
                                    n.latch = 1'b0;
                                `OPC_STATUS_READ:
                                begin
                                    n.state    = DEV_STATUS;
                                    n.outShift = statusByte;
                                    n.fresh    = 1'b1;
                                end
                                `OPC_STATUS_WRITE:
                                    n.state = DEV_SWRITE;
                                `OPC_READ, `OPC_WRITE:
                                begin
                                    n.state       = DEV_ADDR;
                                    n.addr[AW-1]  = b[3];
                                    n.isRead      = b[0];
                                    n.pageMask    = 8'h00;
                                end
                                default:
                                    n.state = DEV_IGNORE;
                            endcase
                        end
                    end
                    DEV_ADDR:
                    begin
                        n.addr[7:0] = b;
                        if (r.isRead)
                        begin
                            n.state    = DEV_RDATA;
                            n.outShift = r.mem[{r.addr[AW-1], b}];
                            n.fresh    = 1'b1;
                        end
                        else
                            n.state = DEV_WDATA;
                    end
                    DEV_WDATA:
                    begin
                        n.page[r.addr[2:0]]     = b;
                        n.pageMask[r.addr[2:0]] = 1'b1;
                        n.addr[2:0]             = r.addr[2:0] + 3'h1;
                        n.gotByte               = 1'b1;
                    end
                    DEV_SWRITE:
                    begin
                        n.pendLevel = b[`ST_LEVEL_HI:`ST_LEVEL_LO];
                        n.gotByte   = 1'b1;
                    end
                    DEV_RDATA:
                    begin
                        nextAddr   = r.addr + AW'(1);
                        n.addr     = nextAddr;
                        n.outShift = r.mem[nextAddr];
                        n.fresh    = 1'b1;
                    end
                    DEV_STATUS:
                    begin
                        n.outShift = statusByte;
                        n.fresh    = 1'b1;
                    end
                    default:
                        n.state = DEV_IGNORE;
                endcase
            end
        end
        else if (!r.held && fall && (r.state == DEV_RDATA || r.state == DEV_STATUS))
        begin
            if (r.fresh)
            begin
                n.fresh  = 1'b0;
                n.outEna = 1'b1;
            end
            else
                n.outShift = {r.outShift[6:0], 1'b0};
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            r <= '0;
        else
            r <= n;
    end

    assign link.soOut = r.outShift[7];
    assign link.soOe  = !r.csS[1] && !r.held && r.outEna && (r.state == DEV_RDATA || r.state == DEV_STATUS);
    assign writeBusy    = (r.pend != PEND_NONE);
    assign protectLevel = r.level;
endmodule : spi_eeprom_dev

// ===== hw/spi_eeprom_host.sv
// serial eeprom controller end: apb registers drive one framed transfer
`timescale 1ns/10ps
`include "eeprom_cfg.svh"
module spi_eeprom_host #(
    parameter int HALF_CYCLES = `SCK_HALF_CYCLES,
    parameter int CS_CYCLES   = `CS_CYCLES
) (
    input  logic        clk,
    input  logic        rst_b,
    input  logic [7:0]  paddr,
    input  logic        psel,
    input  logic        penable,
    input  logic        pwrite,
    input  logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic        pready,
    output logic        pslverr,
    eeprom_if.host      link
);
    import eeprom_pkg::*;

    typedef struct packed {
        eeprom_pkg::host_state_t state;
        logic [7:0]              opcode;
        logic                    hasAddr;
        logic [3:0]              nData;
        logic [7:0]              addrByte;
        logic [63:0]             txData;
        logic [63:0]             rxData;
        logic                    pause;
        logic                    wpLevel;
        logic                    done;
        logic [1:0]              soS;
        logic [7:0]              shift;
        logic [7:0]              rxByte;
        logic [2:0]              bitCnt;
        logic [4:0]              byteIdx;
        logic [4:0]              byteTot;
        logic [7:0]              divCnt;
        logic                    sck;
        logic                    csN;
        logic                    holdN;
        logic [31:0]             rdata;
    } host_regs_t;

    host_regs_t r;
    host_regs_t n;

    logic mapped;
    assign mapped = (paddr[1:0] == 2'h0) && (paddr <= `REG_STATUS);

    always_comb
    begin
        logic [4:0] k;
        logic [7:0] nb;
        k  = 5'h0;
        nb = 8'h00;
        n = r;
        n.soS = {r.soS[0], link.so};
        // apb: read data latched in setup, write taken in access
        if (psel && !penable)
        begin
            case (paddr)
                `REG_CMD:    n.rdata = {19'h0, r.nData, r.hasAddr, r.opcode};
                `REG_ADDR:   n.rdata = {24'h0, r.addrByte};
                `REG_WDATA0: n.rdata = r.txData[31:0];
                `REG_WDATA1: n.rdata = r.txData[63:32];
                `REG_RDATA0: n.rdata = r.rxData[31:0];
                `REG_RDATA1: n.rdata = r.rxData[63:32];
                `REG_CTRL:   n.rdata = {30'h0, r.wpLevel, r.pause};
                `REG_STATUS: n.rdata = {29'h0, !r.holdN, r.done, r.state != HOST_IDLE};
                default:     n.rdata = 32'h0;
            endcase
        end
        if (psel && penable && pwrite)
        begin
            case (paddr)
                `REG_CMD:
                    if (r.state == HOST_IDLE)
                    begin
                        n.opcode  = pwdata[7:0];
                        n.hasAddr = pwdata[`CMD_HAS_ADDR];
                        n.nData   = pwdata[12:9];
                        n.byteTot = 5'h1 + {4'h0, pwdata[`CMD_HAS_ADDR]} + {1'b0, pwdata[12:9]};
                        n.shift   = pwdata[7:0];
                        n.byteIdx = 5'h0;
                        n.bitCnt  = 3'h0;
                        n.csN     = 1'b0;
                        n.divCnt  = 8'(CS_CYCLES - 1);
                        n.state   = HOST_SHIFT;
                    end
                `REG_ADDR:   n.addrByte = pwdata[7:0];
                `REG_WDATA0: n.txData[31:0] = pwdata;
                `REG_WDATA1: n.txData[63:32] = pwdata;
                `REG_CTRL:
                begin
                    n.pause   = pwdata[`CTRL_PAUSE];
                    n.wpLevel = pwdata[`CTRL_WP_LEVEL];
                end
                `REG_STATUS:
                    if (pwdata[`HST_DONE])
                        n.done = 1'b0;
                default:
                    n.done = r.done;
            endcase
        end
        if (r.divCnt != 8'h0)
            n.divCnt = r.divCnt - 8'h1;
        else if (r.state != HOST_IDLE)
        begin
            case (r.state)
                HOST_SHIFT:
                begin
                    n.divCnt = 8'(HALF_CYCLES - 1);
                    if (!r.sck)
                    begin
                        if (r.holdN == r.pause)
                            n.holdN = !r.pause;
                        else if (!r.pause)
                            n.sck = 1'b1;
                    end
                    else
                    begin
                        n.sck    = 1'b0;
                        n.rxByte = {r.rxByte[6:0], r.soS[1]};
                        n.shift  = {r.shift[6:0], 1'b0};
                        n.bitCnt = r.bitCnt + 3'h1;
                        if (r.bitCnt == 3'h7)
                        begin
                            n.rxData  = {r.rxData[55:0], r.rxByte[6:0], r.soS[1]};
                            k         = r.byteIdx + 5'h1;
                            n.byteIdx = k;
                            if (r.hasAddr && k == 5'h1)
                                nb = r.addrByte;
                            else
                                nb = r.txData[{(k[2:0] - 3'h1 - {2'h0, r.hasAddr}), 3'h0} +: 8];
                            n.shift = nb;
                            if (k == r.byteTot)
                                n.state = HOST_DESELECT;
                        end
                    end
                end
                HOST_DESELECT:
                begin
                    n.csN    = 1'b1;
                    n.divCnt = 8'(CS_CYCLES - 1);
                    n.state  = HOST_RECOVER;
                end
                HOST_RECOVER:
                begin
                    n.done  = 1'b1;
                    n.state = HOST_IDLE;
                end
                default:
                    n.state = HOST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            r         <= '0;
            r.csN     <= 1'b1;
            r.holdN   <= 1'b1;
            r.wpLevel <= 1'b1;
        end
        else
            r <= n;
    end

    assign pready     = 1'b1;
    assign pslverr    = psel && penable && !mapped;
    assign prdata     = r.rdata;
    assign link.csN   = r.csN;
    assign link.sck   = r.sck;
    assign link.si    = r.shift[7];
    assign link.holdN = r.holdN;
    assign link.wpN   = r.wpLevel;
endmodule : spi_eeprom_host

// ===== bench/spi_eeprom_checker.sv
// assertions watching the serial eeprom link
`timescale 1ns/10ps
module spi_eeprom_checker #(
    parameter int WC = 1000
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic csN,
    input wire logic sck,
    input wire logic holdN,
    input wire logic soOe,
    input wire logic writeBusy
);
    logic [15:0] busyCnt;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    sequence frameStart;
        $fell(csN);
    endsequence
    sequence frameEnd;
        $rose(csN);
    endsequence
    // counts cycles of the running write
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
            busyCnt <= 16'h0000;
        else
            busyCnt <= writeBusy ? busyCnt + 16'h0001 : 16'h0000;
    a_idle_clock_low: assert property (csN |-> !sck)
        else $error("clock moved while deselected");
    a_select_setup: assert property (frameStart |-> !sck[*8])
        else $error("clock rose too soon after select");
    a_opcode_quiet: assert property (frameStart |-> !soOe[*8])
        else $error("output driven during opcode");
    a_clock_high_time: assert property ($rose(sck) |=> sck[*3] ##1 !sck)
        else $error("clock high phase wrong length");
    a_release_after: assert property (frameEnd |-> ##[1:5] !soOe)
        else $error("output not released after deselect");
    a_deselect_off: assert property (csN[*6] |-> !soOe)
        else $error("output driven while deselected");
    a_held_off: assert property (!holdN[*6] |-> !soOe)
        else $error("output driven while paused");
    a_hold_low_phase: assert property ($changed(holdN) |-> !sck || !$past(sck))
        else $error("pause changed during clock high");
    a_busy_after_select: assert property ($rose(writeBusy) |-> csN && $past(csN, 2))
        else $error("write began without deselect");
    a_busy_length: assert property ($fell(writeBusy) |-> busyCnt == WC)
        else $error("write cycle length wrong");
endmodule : spi_eeprom_checker

// ===== bench/tb_spi_serial_eeprom_slave.sv
// self-checking bench for both ends of the serial eeprom link
`timescale 1ns/10ps
`include "eeprom_cfg.svh"
module tb_spi_serial_eeprom_slave;
    import eeprom_pkg::*;
    localparam int WC = 1000;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        writeBusy;
    logic [1:0]  protectLevel;
    logic [31:0] rd;
    logic        err;
    int          mismatches = 0;
    int          compares = 0;
    eeprom_if link();
    always #12.5 clk = ~clk;
    spi_eeprom_dev #(.WC_CYCLES(WC)) u_spi_eeprom_dev (.clk(clk), .rst_b(rst_b), .link(link.dev),
        .writeBusy(writeBusy), .protectLevel(protectLevel));
    spi_eeprom_host u_spi_eeprom_host (.clk(clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link.host));
    spi_eeprom_checker #(.WC(WC)) u_spi_eeprom_checker (.clk(clk), .rst_b(rst_b), .csN(link.csN),
        .sck(link.sck), .holdN(link.holdN), .soOe(link.soOe), .writeBusy(writeBusy));
    task automatic finish_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            mismatches++;
            finish_test();
        end
    endtask : apb
    function automatic logic [12:0] cm(input logic [7:0] op, input logic a, input logic [3:0] n);
        return {n, a, op};
    endfunction : cm
    task automatic start(input logic [12:0] c, input logic [7:0] a, input logic [31:0] w0);
        apb(1'b1, `REG_WDATA0, w0);
        apb(1'b1, `REG_ADDR, {24'h000000, a});
        apb(1'b1, `REG_CMD, {19'h00000, c});
    endtask : start
    task automatic finish_frame;
        int i;
        for (i = 0; i < 400; i++)
        begin
            apb(1'b0, `REG_STATUS, 32'h0);
            if (rd[`HST_DONE] === 1'b1)
                break;
        end
        if (i == 400)
        begin
            mismatches++;
            finish_test();
        end
        apb(1'b1, `REG_STATUS, 32'h00000002);
        apb(1'b0, `REG_RDATA0, 32'h0);
    endtask : finish_frame
    task automatic frame(input logic [12:0] c, input logic [7:0] a, input logic [31:0] w0);
        start(c, a, w0);
        finish_frame();
    endtask : frame
    task automatic stat(input logic [7:0] exp);
        frame(cm(8'h05, 1'b0, 4'h1), 8'h00, 32'h0);
        chk("status byte", {24'h000000, exp}, {24'h000000, rd[7:0]});
    endtask : stat
    task automatic readB(input logic [7:0] op, input logic [7:0] a, input logic [3:0] n, input logic [31:0] exp);
        frame(cm(op, 1'b1, n), a, 32'h0);
        chk("read data", exp, (n == 4'h4) ? rd : {24'h000000, rd[7:0]});
    endtask : readB
    task automatic waitIdle;
        int i;
        for (i = 0; i < 30; i++)
        begin
            frame(cm(8'h05, 1'b0, 4'h1), 8'h00, 32'h0);
            if (rd[0] === 1'b0)
                break;
        end
        if (i == 30)
        begin
            mismatches++;
            finish_test();
        end
    endtask : waitIdle
    initial
    begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        apb(1'b0, `REG_CTRL, 32'h0);
        chk("ctrl reset", 32'h00000002, rd);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped error", 32'h00000001, {31'h0, err});
        stat(8'h00);
        frame(cm(8'h02, 1'b1, 4'h1), 8'h10, 32'h000000AA);
        stat(8'h00);
        readB(8'h03, 8'h10, 4'h1, 32'h00000000);
        $display("test reset and refused write done");
        frame(cm(8'h0E, 1'b0, 4'h0), 8'h00, 32'h0);
        stat(8'h02);
        apb(1'b1, `REG_CTRL, 32'h0);
        frame(cm(8'h0C, 1'b0, 4'h0), 8'h00, 32'h0);
        stat(8'h00);
        frame(cm(8'h06, 1'b0, 4'h0), 8'h00, 32'h0);
        stat(8'h00);
        apb(1'b1, `REG_CTRL, 32'h00000002);
        $display("test latch done");
        frame(cm(8'h06, 1'b0, 4'h0), 8'h00, 32'h0);
        frame(cm(8'h0A, 1'b1, 4'h3), 8'hFE, 32'h00332211);
        apb(1'b1, `REG_CTRL, 32'h0);
        readB(8'h0B, 8'hFE, 4'h1, 32'h000000FF);
        stat(8'hFF);
        waitIdle();
        apb(1'b1, `REG_CTRL, 32'h00000002);
        stat(8'h00);
        readB(8'h0B, 8'hFE, 4'h4, 32'h11220000);
        readB(8'h0B, 8'hF8, 4'h1, 32'h00000033);
        $display("test page write done");
        frame(cm(8'h06, 1'b0, 4'h0), 8'h00, 32'h0);
        frame(cm(8'h01, 1'b0, 4'h1), 8'h00, 32'h00000004);
        waitIdle();
        stat(8'h04);
        chk("protect level", 32'h00000001, {30'h0, protectLevel});
        frame(cm(8'h06, 1'b0, 4'h0), 8'h00, 32'h0);
        frame(cm(8'h0A, 1'b1, 4'h1), 8'hFE, 32'h00000077);
        readB(8'h0B, 8'hFE, 4'h1, 32'h00000011);
        frame(cm(8'h0A, 1'b1, 4'h1), 8'h7F, 32'h0000005A);
        waitIdle();
        readB(8'h0B, 8'h7F, 4'h1, 32'h0000005A);
        $display("test protect done");
        frame(cm(8'h06, 1'b0, 4'h0), 8'h00, 32'h0);
        apb(1'b1, `REG_CTRL, 32'h0);
        frame(cm(8'h02, 1'b1, 4'h1), 8'h10, 32'h0000005A);
        apb(1'b1, `REG_CTRL, 32'h00000002);
        readB(8'h03, 8'h10, 4'h1, 32'h00000000);
        readB(8'h87, 8'h00, 4'h1, 32'h000000FF);
        $display("test protect pin and bad opcode done");
        start(cm(8'h0B, 1'b1, 4'h1), 8'hFE, 32'h0);
        repeat (100) @(posedge clk);
        apb(1'b1, `REG_CTRL, 32'h00000003);
        repeat (60) @(posedge clk);
        apb(1'b0, `REG_STATUS, 32'h0);
        chk("pause held", 32'h00000001, {31'h0, rd[`HST_HELD]});
        apb(1'b1, `REG_CTRL, 32'h00000002);
        finish_frame();
        chk("paused read", 32'h00000011, {24'h000000, rd[7:0]});
        $display("test pause done");
        finish_test();
    end
endmodule : tb_spi_serial_eeprom_slave
